// ==== src/dpsc_consts.vh ====
`ifndef DPSC_CONSTS_VH
`define DPSC_CONSTS_VH
// Clock period in picoseconds
`define DPSC_CLK_PS 4000
// Device timing figures in ns
`define DPSC_T_RC_NS 25
`define DPSC_T_PWE_NS 20
`define DPSC_T_SD_NS 15
`define DPSC_T_HZWE_NS 15
`define DPSC_T_WH_NS 17
`define DPSC_T_BDD_NS 25
`define DPSC_T_SOP_NS 12
`define DPSC_T_SWRD_NS 5
`define DPSC_T_SAA_NS 25
`define DPSC_T_PS_NS 5
// Least times round up
`define DPSC_CYC_UP(ns) (((ns) * 1000 + `DPSC_CLK_PS - 1) / `DPSC_CLK_PS)
`define DPSC_AW 14
`define DPSC_DW 8
`define DPSC_SEM_AW 3
`define DPSC_CNT_W 4
`define DPSC_SEM_FREE 8'h01
`define DPSC_SEM_TAKE 8'h00
`endif

// ==== src/dpsc_timer.v ====
`include "dpsc_consts.vh"
module dpsc_timer (
  clk,
  resetn,
  load,
  load_val,
  done
);
  input wire clk;
  input wire resetn;
  input wire load;
  input wire [`DPSC_CNT_W-1:0] load_val;
  output wire done;
  reg [`DPSC_CNT_W-1:0] cnt_q;
  // Done depends on the count only, so loads never loop back into it
  assign done = (cnt_q == {`DPSC_CNT_W{1'b0}});
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      cnt_q <= {`DPSC_CNT_W{1'b0}};
    else if (load)
      cnt_q <= load_val;
    else if (cnt_q != {`DPSC_CNT_W{1'b0}})
      cnt_q <= cnt_q - 1'b1;
  end
endmodule

// ==== src/dpsc_port_ctrl.v ====
`include "dpsc_consts.vh"
module dpsc_port_ctrl (
  clk,
  resetn,
  req_valid,
  req_ready,
  req_write,
  req_flag,
  req_addr,
  req_wdata,
  rsp_valid,
  rsp_rdata,
  retain,
  mem_addr,
  mem_ce_n,
  flag_select_n,
  mem_rw_n,
  mem_oe_n,
  mem_dq_o,
  mem_dq_oe,
  mem_dq_i,
  mem_busy_n
);
  input wire clk;
  input wire resetn;
  input wire req_valid;
  output wire req_ready;
  input wire req_write;
  input wire req_flag;
  input wire [`DPSC_AW-1:0] req_addr;
  input wire [`DPSC_DW-1:0] req_wdata;
  output reg rsp_valid;
  output reg [`DPSC_DW-1:0] rsp_rdata;
  input wire retain;
  output reg [`DPSC_AW-1:0] mem_addr;
  output reg mem_ce_n;
  output reg flag_select_n;
  output reg mem_rw_n;
  output reg mem_oe_n;
  output reg [`DPSC_DW-1:0] mem_dq_o;
  output reg mem_dq_oe;
  input wire [`DPSC_DW-1:0] mem_dq_i;
  input wire mem_busy_n;

  localparam [2:0] S_PWRUP = 3'h0;
  localparam [2:0] S_IDLE = 3'h1;
  localparam [2:0] S_SETUP = 3'h2;
  localparam [2:0] S_WPULSE = 3'h3;
  localparam [2:0] S_RWAIT = 3'h4;
  localparam [2:0] S_REC = 3'h5;
  localparam [2:0] S_BUSY = 3'h6;

  // Rounded-up cycle count, cut to counter width
  function [`DPSC_CNT_W-1:0] cyc;
    input integer ns;
    integer t;
    begin
      t = `DPSC_CYC_UP(ns);
      cyc = t[`DPSC_CNT_W-1:0];
    end
  endfunction

  localparam [`DPSC_CNT_W-1:0] C_ONE = 4'h1;
  localparam [`DPSC_CNT_W-1:0] C_RD = cyc(`DPSC_T_RC_NS);
  localparam [`DPSC_CNT_W-1:0] C_RC = C_RD + C_ONE;
  localparam [`DPSC_CNT_W-1:0] C_WP = cyc(`DPSC_T_HZWE_NS + `DPSC_T_SD_NS);
  localparam [`DPSC_CNT_W-1:0] C_SOP = cyc(`DPSC_T_SOP_NS);
  localparam [`DPSC_CNT_W-1:0] C_SWRD = cyc(`DPSC_T_SWRD_NS);
  localparam [`DPSC_CNT_W-1:0] C_WH = cyc(`DPSC_T_WH_NS);
  localparam [`DPSC_CNT_W-1:0] C_BDD = cyc(`DPSC_T_BDD_NS);

  reg [2:0] state_q;
  reg [`DPSC_DW-1:0] dq_s1_q;
  reg [`DPSC_DW-1:0] dq_s2_q;
  reg busy_s1_q;
  reg busy_s2_q;
  reg busy_seen_q;
  reg flag_q;
  reg tload;
  reg [`DPSC_CNT_W-1:0] tval;
  wire tdone;

  dpsc_timer u_timer (
    .clk(clk),
    .resetn(resetn),
    .load(tload),
    .load_val(tval),
    .done(tdone)
  );

  // Largest of two cycle counts
  function [`DPSC_CNT_W-1:0] cmax;
    input [`DPSC_CNT_W-1:0] a;
    input [`DPSC_CNT_W-1:0] b;
    begin
      cmax = (a > b) ? a : b;
    end
  endfunction

  assign req_ready = (state_q == S_IDLE) && !retain;

  // Pin inputs pass two flip-flops
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      dq_s1_q <= {`DPSC_DW{1'b0}};
      dq_s2_q <= {`DPSC_DW{1'b0}};
      busy_s1_q <= 1'b1;
      busy_s2_q <= 1'b1;
    end
    else
    begin
      dq_s1_q <= mem_dq_i;
      dq_s2_q <= dq_s1_q;
      busy_s1_q <= mem_busy_n;
      busy_s2_q <= busy_s1_q;
    end
  end

  // Timer loads
  always @*
  begin
    tload = 1'b0;
    tval = C_ONE;
    case (state_q)
      S_PWRUP:
      begin
        tload = 1'b1;
        tval = C_RC;
      end
      S_IDLE:
        if (req_valid && !retain)
        begin
          tload = 1'b1;
          tval = C_ONE;
        end
      S_SETUP:
        if (tdone)
        begin
          tload = 1'b1;
          // Stretched pulse covers turn-off plus set-up
          if (busy_seen_q)
            tval = cmax(C_WP, C_SOP);
          else
            tval = C_RD;
        end
      S_WPULSE:
        if (!busy_s2_q)
        begin
          tload = 1'b1;
          tval = C_WH;
        end
        else if (tdone)
        begin
          tload = 1'b1;
          tval = flag_q ? C_SWRD : C_ONE;
        end
      S_RWAIT:
        if (!busy_s2_q)
        begin
          tload = 1'b1;
          tval = C_BDD;
        end
        else if (tdone)
        begin
          tload = 1'b1;
          tval = C_ONE;
        end
      S_BUSY:
        if (!busy_s2_q)
        begin
          tload = 1'b1;
          tval = mem_rw_n ? C_BDD : C_WH;
        end
      default:
        tload = 1'b0;
    endcase
  end

  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_q <= S_PWRUP;
      mem_addr <= {`DPSC_AW{1'b0}};
      mem_ce_n <= 1'b1;
      flag_select_n <= 1'b1;
      mem_rw_n <= 1'b1;
      mem_oe_n <= 1'b1;
      mem_dq_o <= {`DPSC_DW{1'b0}};
      mem_dq_oe <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_rdata <= {`DPSC_DW{1'b0}};
      busy_seen_q <= 1'b0;
      flag_q <= 1'b0;
    end
    else
    begin
      rsp_valid <= 1'b0;
      case (state_q)
        S_PWRUP:
          state_q <= S_REC;
        S_IDLE:
          if (req_valid && !retain)
          begin
            // Address moves only while strobe is high
            mem_addr <= req_addr;
            mem_rw_n <= 1'b1;
            flag_q <= req_flag;
            mem_dq_o <= req_wdata;
            if (req_flag)
            begin
              mem_addr <= {{(`DPSC_AW-`DPSC_SEM_AW){1'b0}},
                req_addr[`DPSC_SEM_AW-1:0]};
              mem_ce_n <= 1'b1;
              flag_select_n <= 1'b0;
            end
            else
            begin
              mem_ce_n <= 1'b0;
              flag_select_n <= 1'b1;
            end
            mem_oe_n <= req_write;
            state_q <= S_SETUP;
            busy_seen_q <= req_write;
          end
        S_SETUP:
          if (tdone)
          begin
            if (busy_seen_q)
            begin
              // Select already low, strobe falls after it
              mem_rw_n <= 1'b0;
              mem_dq_oe <= 1'b1;
              mem_oe_n <= 1'b1;
              state_q <= S_WPULSE;
            end
            else
              state_q <= S_RWAIT;
          end
        S_WPULSE:
          if (!busy_s2_q)
            state_q <= S_BUSY;
          else if (tdone)
          begin
            // Both strobes rise together; data held through edge
            mem_rw_n <= 1'b1;
            mem_ce_n <= 1'b1;
            flag_select_n <= 1'b1;
            state_q <= S_REC;
          end
        S_RWAIT:
          if (!busy_s2_q)
          begin
            busy_seen_q <= 1'b1;
            state_q <= S_BUSY;
          end
          else if (tdone)
          begin
            rsp_rdata <= dq_s2_q;
            rsp_valid <= 1'b1;
            mem_ce_n <= 1'b1;
            flag_select_n <= 1'b1;
            mem_oe_n <= 1'b1;
            state_q <= S_REC;
          end
        S_BUSY:
          if (busy_s2_q)
          begin
            // Waiting for tdone after busy clears
            if (tdone)
            begin
              if (mem_rw_n)
              begin
                rsp_rdata <= dq_s2_q;
                rsp_valid <= 1'b1;
                mem_oe_n <= 1'b1;
              end
              mem_rw_n <= 1'b1;
              mem_ce_n <= 1'b1;
              flag_select_n <= 1'b1;
              state_q <= S_REC;
            end
          end
        S_REC:
          if (tdone)
          begin
            mem_dq_oe <= 1'b0;
            state_q <= S_IDLE;
          end
        default:
          state_q <= S_IDLE;
      endcase
    end
  end
endmodule

// ==== tb/dpsc_monitor.sv ====
`include "dpsc_consts.vh"
module dpsc_monitor (
  input logic clk,
  input logic resetn,
  input logic retain,
  input logic mem_busy_n,
  input logic req_ready,
  input logic [`DPSC_AW-1:0] mem_addr,
  input logic mem_ce_n,
  input logic flag_select_n,
  input logic mem_rw_n,
  input logic mem_oe_n,
  input logic mem_dq_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);
  sequence s_wr_start;
    $fell(mem_rw_n);
  endsequence
  sequence s_wr_hold;
    (!mem_rw_n && mem_oe_n) [*8];
  endsequence
  a_one_select: assert property (!(!mem_ce_n && !flag_select_n))
    else $error("both selects low");
  a_addr_still: assert property (!$stable(mem_addr) |-> mem_rw_n)
    else $error("address moved in write");
  a_pulse_wide: assert property (s_wr_start |-> s_wr_hold)
    else $error("write pulse short");
  a_end_hold: assert property ($rose(mem_rw_n) |-> mem_dq_oe)
    else $error("data dropped at write end");
  a_retain_high: assert property (retain && mem_ce_n |=> mem_ce_n)
    else $error("select in retention");
  a_busy_wait: assert property
    ($rose(mem_busy_n) |-> (!$rose(mem_rw_n)) [*5])
    else $error("write ended early after busy");
  a_flag_gap: assert property
    ($rose(flag_select_n) && $rose(mem_rw_n) |-> flag_select_n [*2])
    else $error("flag read too soon");
  a_power_wait: assert property
    ($rose(resetn) |-> (!req_ready && mem_ce_n) [*7])
    else $error("access too soon after start");
endmodule
bind dpsc_port_ctrl dpsc_monitor dpsc_monitor_i (.clk, .resetn, .retain,
  .mem_busy_n, .req_ready, .mem_addr, .mem_ce_n, .flag_select_n,
  .mem_rw_n, .mem_oe_n, .mem_dq_oe);

// ==== tb/dpsc_dev_model.sv ====
`include "dpsc_consts.vh"
module dpsc_dev_model (
  input logic clk,
  input logic [`DPSC_AW-1:0] addr,
  input logic ce_n,
  input logic sem_n,
  input logic rw_n,
  input logic oe_n,
  input logic [`DPSC_DW-1:0] dq,
  input logic busy,
  output logic [`DPSC_DW-1:0] q,
  output logic busy_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [`DPSC_DW-1:0] mem [0:(1<<`DPSC_AW)-1];
  logic [7:0] flag = 8'hFF;
  logic [`DPSC_DW-1:0] last = 8'h00;
  // Busy reaches the port only while it selects the array
  assign busy_n = !(busy && !ce_n);
  // Blocked port writes nothing
  always @(posedge clk)
  begin
    if (!rw_n && !ce_n && !busy)
      mem[addr] <= dq;
    if (!rw_n && !sem_n && !busy)
      // Lone requester's flag write takes effect whenever busy is low
      flag[addr[2:0]] <= dq[0];
    last <= q;
  end
  // Released bus toggles
  always @*
    if (!oe_n && rw_n && !ce_n && sem_n && !busy)
      q = mem[addr];
    else if (!oe_n && rw_n && !sem_n && ce_n)
      q = flag[addr[2:0]] ? `DPSC_SEM_FREE : `DPSC_SEM_TAKE;
    else
      q = ~last;
endmodule

// ==== tb/tb_top.sv ====
`include "dpsc_consts.vh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0;
  logic resetn = 0;
  logic req_valid = 0;
  logic req_write = 0;
  logic req_flag = 0;
  logic [`DPSC_AW-1:0] req_addr = 14'h0000;
  logic [`DPSC_DW-1:0] req_wdata = 8'h00;
  logic retain = 0;
  logic busy = 0;
  logic req_ready, rsp_valid, mem_ce_n, flag_select_n, mem_rw_n;
  logic mem_oe_n, mem_dq_oe, mem_busy_n;
  logic [`DPSC_AW-1:0] mem_addr;
  logic [`DPSC_DW-1:0] rsp_rdata, mem_dq_o, mem_dq_i, dev_q;
  int miscompares = 0;
  int total_checks = 0;
  always #2 clk = ~clk;
  assign mem_dq_i = mem_dq_oe ? mem_dq_o : dev_q;
  dpsc_port_ctrl dpsc_port_ctrl_i (.clk, .resetn, .req_valid, .req_ready,
    .req_write, .req_flag, .req_addr, .req_wdata, .rsp_valid, .rsp_rdata,
    .retain, .mem_addr, .mem_ce_n, .flag_select_n, .mem_rw_n, .mem_oe_n,
    .mem_dq_o, .mem_dq_oe, .mem_dq_i, .mem_busy_n);
  dpsc_dev_model dpsc_dev_model_i (.clk, .addr(mem_addr), .ce_n(mem_ce_n),
    .sem_n(flag_select_n), .rw_n(mem_rw_n), .oe_n(mem_oe_n),
    .dq(mem_dq_i), .busy, .q(dev_q), .busy_n(mem_busy_n));
  task automatic finish_test;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("BAD %0t seen %h want %h", $time, seen, exp);
    end
  endtask
  // Settled values are looked at on the falling edge
  task automatic wait_hi(input bit rsp);
    int n;
    n = 0;
    do
    begin
      @(negedge clk);
      n++;
    end
    while ((rsp ? rsp_valid : req_ready) !== 1'b1 && n < 200);
    if (n >= 200)
    begin
      miscompares++;
      $display("BAD %0t timeout", $time);
      finish_test;
    end
  endtask
  task automatic op(input logic w, f, input logic [`DPSC_AW-1:0] a,
    input logic [7:0] d, output logic [7:0] r);
    @(posedge clk);
    req_valid <= 1'b1;
    req_write <= w;
    req_flag <= f;
    req_addr <= a;
    req_wdata <= d;
    wait_hi(0);
    @(posedge clk);
    req_valid <= 1'b0;
    r = 8'h00;
    if (!w)
    begin
      wait_hi(1);
      r = rsp_rdata;
    end
  endtask
  task automatic t_array;
    logic [7:0] r;
    op(1, 0, 14'h3FFF, 8'hA5, r);
    op(1, 0, 14'h0000, 8'h5A, r);
    op(0, 0, 14'h3FFF, 8'h00, r);
    check(r, 8'hA5);
    op(0, 0, 14'h0000, 8'h00, r);
    check(r, 8'h5A);
  endtask
  task automatic t_flag;
    logic [7:0] r;
    op(0, 1, 14'h0003, 8'h00, r);
    check(r, `DPSC_SEM_FREE);
    op(1, 1, 14'h0003, `DPSC_SEM_TAKE, r);
    op(0, 1, 14'h0003, 8'h00, r);
    check(r, `DPSC_SEM_TAKE);
    op(1, 1, 14'h0003, `DPSC_SEM_FREE, r);
    op(0, 1, 14'h0003, 8'h00, r);
    check(r, `DPSC_SEM_FREE);
  endtask
  task automatic t_busy;
    logic [7:0] r;
    for (int i = 0; i < 2; i++)
    begin
      @(posedge clk);
      busy <= 1'b1;
      fork
        op(i == 0, 0, 14'h0155, 8'h3C, r);
        begin
          repeat (30) @(posedge clk);
          busy <= 1'b0;
        end
      join
      // Let the blocked transfer finish before the next one
      wait_hi(0);
    end
    check(r, 8'h3C);
  endtask
  task automatic t_retain;
    logic [7:0] r;
    @(posedge clk);
    retain <= 1'b1;
    repeat (20) @(negedge clk);
    check({7'h00, req_ready, mem_ce_n}, 8'h01);
    @(posedge clk);
    retain <= 1'b0;
    op(0, 0, 14'h0000, 8'h00, r);
    check(r, 8'h5A);
  endtask
  initial
  begin
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    t_array;
    t_flag;
    t_busy;
    t_retain;
    finish_test;
  end
endmodule
